// ===== hw/emd_defines.vh
// register offsets, field positions, reset values and timing counts for the eye monitor bank
`ifndef EMD_DEFINES_VH
`define EMD_DEFINES_VH

`define EMD_ADDR_CMD_STATUS    8'h24
`define EMD_ADDR_COUNT_HIGH    8'h25
`define EMD_ADDR_COUNT_LOW     8'h26
`define EMD_ADDR_HORIZ_RESULT  8'h27
`define EMD_ADDR_VERT_RESULT   8'h28
`define EMD_ADDR_RANGE_RDBK    8'h29
`define EMD_ADDR_TIMER_THRESH  8'h2A
`define EMD_ADDR_MIN_HIT_CFG   8'h2B
`define EMD_ADDR_MERIT_CFG     8'h2C

`define EMD_BIT_COUNT_START    0
`define EMD_BIT_MEAS_START     1
`define EMD_BIT_ADAPT_START    2
`define EMD_BIT_RSVD3          3
`define EMD_BIT_NO_VERT        4
`define EMD_BIT_NO_HITS        5
`define EMD_BIT_FAST_MODE      7
`define EMD_BIT_SCALE_VERT     6
`define EMD_RANGE_LSB          5
`define EMD_RANGE_MSB          6
`define EMD_MERIT_LSB          4
`define EMD_MERIT_MSB          5
`define EMD_LOOK_LSB           0
`define EMD_LOOK_MSB           3
`define EMD_MINHIT_LSB         0
`define EMD_MINHIT_MSB         3

`define EMD_RST_CMD_STATUS     8'h00
`define EMD_RST_RANGE_RDBK     8'h00
`define EMD_RST_TIMER_THRESH   8'h30
`define EMD_RST_MIN_HIT_CFG    8'h00
`define EMD_RST_MERIT_CFG      8'h72
`define EMD_MERIT_INVALID      2'h0
`define EMD_HORIZ_MAX          8'h3F

// one threshold step of the monitor timer, in ns, and its cycle count at 4 ns per cycle
`define EMD_TIMER_STEP_NS      64
`define EMD_CLK_PERIOD_NS      4
`define EMD_TIMER_STEP_CYC     (`EMD_TIMER_STEP_NS / `EMD_CLK_PERIOD_NS)

`endif

// ===== hw/emd_regs.v
// eye monitor and dfe adaptation control and status register bank
//
// What this block does
// - bit 2 launches adaptation, self clears
// - bit 1 launches opening measurement, self clears
// - bit 0 starts hit counter, self clears
// - bit 5 flags no hits at crossing
// - bit 4 flags vertical eye not visible
// - hit count high byte then low byte
// - horizontal opening 0..63, vertical next byte
// - eye_range_readback bits 6:5 show active voltage range
// - timer threshold register, reset 0x30
// - four bit minimum hits field, reset zero
// - bit 6 scales vertical opening by range
// - figure of merit type, 00 invalid, reset 11
// - look beyond count field, reset 0010
// - bit 7 fast monitor mode enable
`timescale 1ns/1ps
`include "emd_defines.vh"
module emd_regs #(
    parameter TIMER_STEP_CYC = `EMD_TIMER_STEP_CYC
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // register port
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // voltage range configured elsewhere
    input  wire [1:0] range_cfg,
    // eye sampler
    input  wire       hit_pulse,
    // opening measurement engine
    input  wire       meas_done,
    input  wire [7:0] meas_horiz,
    input  wire [7:0] meas_vert_raw,
    input  wire       meas_no_hits,
    input  wire       meas_no_vert,
    output reg        meas_start,
    // adaptation engine
    input  wire       adapt_done,
    output reg        adapt_start,
    output reg  [1:0] figure_of_merit_type,
    output reg  [3:0] look_beyond_q,
    // monitor settings
    output reg        fast_mode_q,
    output reg        count_busy
);
    reg  [7:0]  timer_thresh_q;
    reg  [7:0]  min_hit_cfg_q;
    reg  [7:0]  merit_cfg_q;
    reg         rsvd3_q;
    reg         rsvd_rng7_q;
    reg  [4:0]  rsvd_rng_lo_q;
    reg  [1:0]  range_q;
    reg         no_hits_q;
    reg         no_vert_q;
    reg  [15:0] hit_count_q;
    reg  [7:0]  horizontal_eye_opening_q;
    reg  [7:0]  vertical_eye_opening_q;
    reg  [3:0]  meas_hits_q;
    reg  [15:0] step_cnt_q;
    reg  [7:0]  step_num_q;
    wire        wr_cmd;
    wire        cnt_launch;
    wire        meas_launch;
    wire        adapt_launch;
    wire        adapt_refuse;
    wire        cnt_busy;
    wire        meas_busy;
    wire        adapt_busy;
    wire        cnt_start;
    wire        meas_start_w;
    wire        adapt_start_w;
    wire        timer_end;
    wire        cnt_run;
    wire        wr_range;
    wire        wr_timer;
    wire        wr_min_hit;
    wire        wr_merit;
    wire        adapt_finish;
    wire        meas_take;
    wire        hits_short;
    wire        scale_on;
    wire        step_wrap;
    wire        hit_sat;
    wire [1:0]  merit_type_w;
    wire [3:0]  look_w;
    wire [9:0]  range_mult;
    wire [7:0]  img_cmd_status;
    wire [7:0]  img_range;
    reg  [9:0]  vert_scaled;
    reg  [7:0]  vert_next;
    reg  [7:0]  horiz_next;
    reg  [7:0]  rdata_d;

    assign wr_cmd       = reg_wr & (reg_addr == `EMD_ADDR_CMD_STATUS);
    assign cnt_launch   = wr_cmd & reg_wdata[`EMD_BIT_COUNT_START];
    assign meas_launch  = wr_cmd & reg_wdata[`EMD_BIT_MEAS_START];
    // a launch with an invalid merit type never pulses the adaptation engine; the bit drops at once
    assign adapt_refuse = merit_cfg_q[`EMD_MERIT_MSB:`EMD_MERIT_LSB] == `EMD_MERIT_INVALID;
    assign adapt_launch = wr_cmd & reg_wdata[`EMD_BIT_ADAPT_START];
    assign cnt_run      = cnt_busy & ~cnt_start;
    assign timer_end    = cnt_run & (step_cnt_q == 16'h0000) & (step_num_q == 8'h00);
    assign adapt_finish = adapt_done | adapt_refuse;
    assign wr_range     = reg_wr & (reg_addr == `EMD_ADDR_RANGE_RDBK);
    assign wr_timer     = reg_wr & (reg_addr == `EMD_ADDR_TIMER_THRESH);
    assign wr_min_hit   = reg_wr & (reg_addr == `EMD_ADDR_MIN_HIT_CFG);
    assign wr_merit     = reg_wr & (reg_addr == `EMD_ADDR_MERIT_CFG);
    assign meas_take    = meas_done & meas_busy;
    assign hits_short   = meas_hits_q < min_hit_cfg_q[`EMD_MINHIT_MSB:`EMD_MINHIT_LSB];
    assign scale_on     = merit_cfg_q[`EMD_BIT_SCALE_VERT];
    assign step_wrap    = (step_cnt_q == 16'h0000);
    assign hit_sat      = (hit_count_q == 16'hFFFF);
    assign merit_type_w = merit_cfg_q[`EMD_MERIT_MSB:`EMD_MERIT_LSB];
    assign look_w       = merit_cfg_q[`EMD_LOOK_MSB:`EMD_LOOK_LSB];
    assign range_mult   = {8'h00, range_q} + 10'h001;

    // self-clearing command bits; a write of zero cannot abort a running job
    emd_sc_cmd u_cnt_cmd (
        .clk     (clk),
        .rst     (rst),
        .launch  (cnt_launch),
        .finish  (timer_end),
        .busy_q  (cnt_busy),
        .start_q (cnt_start)
    );
    emd_sc_cmd u_meas_cmd (
        .clk     (clk),
        .rst     (rst),
        .launch  (meas_launch),
        .finish  (meas_done),
        .busy_q  (meas_busy),
        .start_q (meas_start_w)
    );
    emd_sc_cmd u_adapt_cmd (
        .clk     (clk),
        .rst     (rst),
        .launch  (adapt_launch),
        .finish  (adapt_finish),
        .busy_q  (adapt_busy),
        .start_q (adapt_start_w)
    );

    // command register: fast mode and the reserved bit are plain storage
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fast_mode_q <= 1'b0;
            rsvd3_q     <= 1'b0;
        end else if (wr_cmd) begin
            fast_mode_q <= reg_wdata[`EMD_BIT_FAST_MODE];
            rsvd3_q     <= reg_wdata[`EMD_BIT_RSVD3];
        end
    end

    // range readback: only the reserved bits are writable, 6:5 follow the range in effect
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rsvd_rng7_q   <= 1'b0;
            rsvd_rng_lo_q <= 5'h00;
        end else if (wr_range) begin
            rsvd_rng7_q   <= reg_wdata[7];
            rsvd_rng_lo_q <= reg_wdata[4:0];
        end
    end

    // timer threshold
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_thresh_q <= `EMD_RST_TIMER_THRESH;
        end else if (wr_timer) begin
            timer_thresh_q <= reg_wdata;
        end
    end

    // minimum hits; reserved upper bits are kept so they read back as written
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            min_hit_cfg_q <= `EMD_RST_MIN_HIT_CFG;
        end else if (wr_min_hit) begin
            min_hit_cfg_q <= reg_wdata;
        end
    end

    // scaling, merit type and look-beyond count
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            merit_cfg_q <= `EMD_RST_MERIT_CFG;
        end else if (wr_merit) begin
            merit_cfg_q <= reg_wdata;
        end
    end

    // range in effect follows the other control register every cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            range_q <= 2'h0;
        end else begin
            range_q <= range_cfg;
        end
    end

    // hit count: cleared at start, counts during the run, saturates at all ones
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hit_count_q <= 16'h0000;
        end else if (cnt_start) begin
            hit_count_q <= 16'h0000;
        end else if (cnt_run && hit_pulse && !hit_sat) begin
            hit_count_q <= hit_count_q + 16'h0001;
        end
    end

    // run timer: threshold steps of TIMER_STEP_CYC cycles each
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            step_cnt_q <= 16'h0000;
            step_num_q <= 8'h00;
        end else if (cnt_start) begin
            step_cnt_q <= TIMER_STEP_CYC[15:0] - 16'h0001;
            step_num_q <= timer_thresh_q;
        end else if (cnt_run) begin
            if (!step_wrap) begin
                step_cnt_q <= step_cnt_q - 16'h0001;
            end else if (step_num_q != 8'h00) begin
                step_cnt_q <= TIMER_STEP_CYC[15:0] - 16'h0001;
                step_num_q <= step_num_q - 8'h01;
            end
        end
    end

    // horizontal opening is clipped to the 0..63 phase range
    always @* begin
        horiz_next = (meas_horiz > `EMD_HORIZ_MAX) ? `EMD_HORIZ_MAX : meas_horiz;
    end

    // vertical opening scaled by the range step, saturating rather than wrapping
    always @* begin
        vert_scaled = {2'b00, meas_vert_raw} * range_mult;
        if (scale_on) begin
            vert_next = (vert_scaled > 10'h0FF) ? 8'hFF : vert_scaled[7:0];
        end else begin
            vert_next = meas_vert_raw;
        end
    end

    // crossing hits seen during the measurement, saturating at the field's top
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meas_hits_q <= 4'h0;
        end else if (meas_start_w) begin
            meas_hits_q <= 4'h0;
        end else if (meas_busy && hit_pulse && meas_hits_q != 4'hF) begin
            meas_hits_q <= meas_hits_q + 4'h1;
        end
    end

    // results change only when a measurement completes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            horizontal_eye_opening_q <= 8'h00;
            vertical_eye_opening_q   <= 8'h00;
        end else if (meas_take) begin
            horizontal_eye_opening_q <= horiz_next;
            vertical_eye_opening_q   <= vert_next;
        end
    end

    // error flags; a done that meets a fresh launch still posts its flags
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            no_hits_q <= 1'b0;
            no_vert_q <= 1'b0;
        end else if (meas_take) begin
            no_hits_q <= meas_no_hits | hits_short;
            no_vert_q <= meas_no_vert;
        end else if (meas_launch) begin
            no_hits_q <= 1'b0;
            no_vert_q <= 1'b0;
        end
    end

    // launch pulses to the engines; a refused adaptation never pulses
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meas_start  <= 1'b0;
            adapt_start <= 1'b0;
        end else begin
            meas_start  <= meas_start_w;
            adapt_start <= adapt_start_w & ~adapt_refuse;
        end
    end

    // counter busy copy for the monitor side
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_busy <= 1'b0;
        end else begin
            count_busy <= cnt_busy;
        end
    end

    // settings for the adaptation engine, reset to the register's reset fields
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            figure_of_merit_type <= 2'h3;
            look_beyond_q        <= 4'h2;
        end else begin
            figure_of_merit_type <= merit_type_w;
            look_beyond_q        <= look_w;
        end
    end

    // status images; bit 6 of the command register reads zero
    assign img_cmd_status = {fast_mode_q, 1'b0, no_hits_q, no_vert_q,
                             rsvd3_q, adapt_busy, meas_busy, cnt_busy};
    assign img_range      = {rsvd_rng7_q, range_q, rsvd_rng_lo_q};

    // read mux; unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `EMD_ADDR_CMD_STATUS:   rdata_d = img_cmd_status;
            `EMD_ADDR_COUNT_HIGH:   rdata_d = hit_count_q[15:8];
            `EMD_ADDR_COUNT_LOW:    rdata_d = hit_count_q[7:0];
            `EMD_ADDR_HORIZ_RESULT: rdata_d = horizontal_eye_opening_q;
            `EMD_ADDR_VERT_RESULT:  rdata_d = vertical_eye_opening_q;
            `EMD_ADDR_RANGE_RDBK:   rdata_d = img_range;
            `EMD_ADDR_TIMER_THRESH: rdata_d = timer_thresh_q;
            `EMD_ADDR_MIN_HIT_CFG:  rdata_d = min_hit_cfg_q;
            `EMD_ADDR_MERIT_CFG:    rdata_d = merit_cfg_q;
            default:                rdata_d = 8'h00;
        endcase
    end

    // read data holds between reads so software sees a steady byte
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end
endmodule // emd_regs

// ===== hw/emd_sc_cmd.v
// one self-clearing command bit with its launch pulse
`timescale 1ns/1ps
module emd_sc_cmd (
    // clock and reset
    input  wire clk,
    input  wire rst,
    // command
    input  wire launch,
    input  wire finish,
    output reg  busy_q,
    output reg  start_q
);
    // a launch in the finishing cycle wins and keeps busy set, but no start pulse issues because busy_q is still high
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q  <= 1'b0;
            start_q <= 1'b0;
        end else begin
            start_q <= launch & ~busy_q;
            if (launch) begin
                busy_q <= 1'b1;
            end else if (finish) begin
                busy_q <= 1'b0;
            end
        end
    end
endmodule // emd_sc_cmd

// ===== tb/emd_regs_assertions.sv
// port checker for the eye monitor register bank
`timescale 1ns/1ps
module emd_regs_assertions #(
    parameter TIMER_STEP_CYC = 2
) (
    // clock and reset
    input wire       clk,
    input wire       rst,
    // register port
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire [1:0] range_cfg,
    // engine and monitor side
    input wire       meas_start,
    input wire       adapt_start,
    input wire [1:0] figure_of_merit_type,
    input wire [3:0] look_beyond_q,
    input wire       fast_mode_q,
    input wire       count_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // longest counter run for an 8-bit threshold, with a little slack
    localparam int RUN_MAX = TIMER_STEP_CYC * 260;
    sequence s_cmd_wr(b);
        reg_wr && reg_addr == 8'h24 && reg_wdata[b];
    endsequence
    chk_meas_launch: assert property (
        meas_start |-> $past(reg_wr && reg_addr == 8'h24 && reg_wdata[1], 2) ##1 !meas_start)
        else $error("measurement start pulse without launch");
    chk_adapt_launch: assert property (
        adapt_start |-> $past(reg_wr && reg_addr == 8'h24 && reg_wdata[2], 2) ##1 !adapt_start)
        else $error("adaptation start pulse without launch");
    chk_merit_invalid: assert property (
        adapt_start |-> figure_of_merit_type != 2'h0)
        else $error("adaptation started with invalid merit type");
    chk_count_start: assert property (
        s_cmd_wr(0) |-> ##2 count_busy)
        else $error("counter did not start");
    chk_count_clear: assert property (
        $rose(count_busy) |-> ##[1:RUN_MAX] !count_busy)
        else $error("counter start bit never cleared");
    chk_fast_mode: assert property (
        reg_wr && reg_addr == 8'h24 |=> fast_mode_q == $past(reg_wdata[7]))
        else $error("fast mode bit not written");
    chk_merit_copy: assert property (
        reg_wr && reg_addr == 8'h2C |-> ##2 figure_of_merit_type == $past(reg_wdata[5:4], 2)
        && look_beyond_q == $past(reg_wdata[3:0], 2))
        else $error("merit settings not applied");
    chk_range_read: assert property (
        reg_rd && reg_addr == 8'h29 |=> reg_rdata[6:5] == $past(range_cfg, 2))
        else $error("range readback wrong");
    chk_horiz_clip: assert property (
        reg_rd && reg_addr == 8'h27 |=> reg_rdata <= 8'h3F)
        else $error("horizontal opening above range");
    chk_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule // emd_regs_assertions

// ===== tb/test_emd_regs.sv
// self-checking bench for the eye monitor register bank
`timescale 1ns/1ps
module test_emd_regs;
    logic       clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, hit_pulse = 1'h0;
    logic       meas_done = 1'h0, meas_no_hits = 1'h0, meas_no_vert = 1'h0, adapt_done = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, meas_horiz = 8'h00, meas_vert_raw = 8'h00;
    logic [1:0] range_cfg = 2'h0;
    wire  [7:0] reg_rdata;
    wire  [1:0] figure_of_merit_type;
    wire  [3:0] look_beyond_q;
    wire        meas_start, adapt_start, fast_mode_q, count_busy;
    logic       got;
    logic [7:0] rst_val [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h72};
    int         error_cnt = 0, checks = 0;
    emd_regs #(.TIMER_STEP_CYC(2)) emd_regs_i (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .range_cfg, .hit_pulse, .meas_done, .meas_horiz, .meas_vert_raw,
        .meas_no_hits, .meas_no_vert, .meas_start, .adapt_done, .adapt_start,
        .figure_of_merit_type, .look_beyond_q, .fast_mode_q, .count_busy);
    always #2 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    // read, mask and compare; data lands on the read edge itself
    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'h1, a};
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata & m, e);
    endtask
    task automatic wait_start(input logic adapt, output logic g);
        g = 1'h0;
        for (int i = 0; i < 12 && !g; i++) begin
            @(posedge clk);
            #1 g = (adapt ? adapt_start : meas_start) === 1'h1;
        end
    endtask
    task automatic meas(input logic [7:0] h, v, input logic nh, nv, input logic [7:0] ef, eh, ev);
        wr(8'h24, 8'h02);
        wait_start(1'h0, got);
        chk({7'h00, got}, 8'h01);
        rc(8'h24, 8'hFF, 8'h02);
        @(posedge clk);
        {meas_done, meas_horiz, meas_vert_raw, meas_no_hits, meas_no_vert} <= {1'h1, h, v, nh, nv};
        @(posedge clk);
        meas_done <= 1'h0;
        rc(8'h24, 8'hFF, ef);
        rc(8'h27, 8'hFF, eh);
        rc(8'h28, 8'hFF, ev);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        for (logic [7:0] a = 8'h24; a <= 8'h2C; a++) rc(a, 8'hFF, rst_val[a - 8'h24]);
        rc(8'h30, 8'hFF, 8'h00);
        chk({6'h00, figure_of_merit_type}, 8'h03);
        chk({4'h0, look_beyond_q}, 8'h02);
        $display("reset test done");
        wr(8'h27, 8'hFF);
        rc(8'h27, 8'hFF, 8'h00);
        wr(8'h24, 8'h80);
        rc(8'h24, 8'h80, 8'h80);
        chk({7'h00, fast_mode_q}, 8'h01);
        wr(8'h24, 8'h00);
        range_cfg <= 2'h1;
        rc(8'h29, 8'h60, 8'h20);
        $display("access test done");
        wr(8'h2A, 8'h04);
        rc(8'h2A, 8'hFF, 8'h04);
        wr(8'h24, 8'h01);
        @(posedge clk);
        hit_pulse <= 1'h1;
        repeat (5) @(posedge clk);
        hit_pulse <= 1'h0;
        chk({7'h00, count_busy}, 8'h01);
        for (int i = 0; i < 40 && count_busy !== 1'h0; i++) @(posedge clk);
        rc(8'h24, 8'h01, 8'h00);
        rc(8'h25, 8'hFF, 8'h00);
        rc(8'h26, 8'hFF, 8'h05);
        $display("counter test done");
        // vertical scaled by range 1 (x2); horizontal clipped to 63
        meas(8'h50, 8'h30, 1'h0, 1'h1, 8'h10, 8'h3F, 8'h60);
        wr(8'h2B, 8'h0F);
        rc(8'h2B, 8'h0F, 8'h0F);
        // no hits seen against a minimum of 15 raises the no-hits flag
        meas(8'h10, 8'hA0, 1'h0, 1'h0, 8'h20, 8'h10, 8'hFF);
        $display("measurement test done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h2C, 8'(k * 16 + 3));
            rc(8'h2C, 8'hFF, 8'(k * 16 + 3));
            chk({6'h00, figure_of_merit_type}, 8'(k));
            chk({4'h0, look_beyond_q}, 8'h03);
            wr(8'h24, 8'h04);
            wait_start(1'h1, got);
            chk({7'h00, got}, {7'h00, k != 0});
            @(posedge clk);
            adapt_done <= 1'h1;
            @(posedge clk);
            adapt_done <= 1'h0;
            rc(8'h24, 8'h04, 8'h00);
        end
        $display("adaptation test done");
        wr(8'h2B, 8'h00);
        // scaling now off and the engine's own flags set: raw vertical, both flags
        meas(8'h20, 8'h90, 1'h1, 1'h1, 8'h30, 8'h20, 8'h90);
        $display("scaling test done");
        final_report;
    end
    initial begin
        #20000;
        error_cnt++;
        final_report;
    end
endmodule // test_emd_regs
bind emd_regs emd_regs_assertions #(.TIMER_STEP_CYC(TIMER_STEP_CYC)) emd_regs_assertions_i (
    .clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .range_cfg, .meas_start,
    .adapt_start, .figure_of_merit_type, .look_beyond_q, .fast_mode_q, .count_busy);
